// *** common/cap_cfg.svh ***
`ifndef CAP_CFG_SVH
`define CAP_CFG_SVH
// ==========================================================
// Register offsets
`define CAP_A0_CNT_LO 8'hA2
`define CAP_A0_CNT_HI 8'hA3
`define CAP_A0_CTRL 8'hA4
`define CAP_STATUS 8'hA5
`define CAP_M0_MODE 8'hA9
`define CAP_M1_MODE 8'hAA
`define CAP_M2_MODE 8'hAB
`define CAP_M0_CMP_LO 8'hAC
`define CAP_M0_CMP_HI 8'hAD
`define CAP_M1_CMP_LO 8'hAF
`define CAP_M1_CMP_HI 8'hB1
`define CAP_M2_CMP_LO 8'hB2
`define CAP_M2_CMP_HI 8'hB3
`define CAP_A0_PERIOD 8'hB4
`define CAP_A1_CNT_LO 8'hBA
`define CAP_A1_CNT_HI 8'hBB
`define CAP_A1_CTRL 8'hBC
`define CAP_M3_MODE 8'hBD
`define CAP_M4_MODE 8'hBE
`define CAP_M5_MODE 8'hBF
`define CAP_M3_CMP_LO 8'hC1
`define CAP_M3_CMP_HI 8'hC2
`define CAP_M4_CMP_LO 8'hC3
`define CAP_M4_CMP_HI 8'hC4
`define CAP_M5_CMP_LO 8'hC5
`define CAP_M5_CMP_HI 8'hC6
`define CAP_A1_PERIOD 8'hC7
`define CAP_A0_PRESCALE 8'hFB
`define CAP_A1_PRESCALE 8'hFC
// ==========================================================
// Field positions
`define CAP_PS_CE_BIT 4
`define CAP_CTRL_RUN_BIT 6
`define CAP_MODE_IE_BIT 6
`define CAP_MODE_CMPEN_BIT 5
`define CAP_CLKSEL_PRESCALE 2'h0
`define CAP_CLKSEL_T0OVF 2'h1
`define CAP_CLKSEL_PIN 2'h2
// ==========================================================
// Reset values
`define CAP_PRESCALE_RST 8'h10
`define CAP_ZERO8 8'h00
`endif

// *** common/cap_pkg.sv ***
package cap_pkg;
  // Mode field, low three bits of a module mode register
  typedef enum logic [2:0] {
    CAP_OFF,
    CAP_CAPTURE,
    CAP_TIMER,
    CAP_TOGGLE,
    CAP_PWM_FIXED,
    CAP_PWM_PROG
  } cap_mode_t;

  typedef struct packed {
    logic ie;
    logic cmp_en;
    logic [1:0] edge_sel;
    cap_mode_t mode;
  } cap_mode_reg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cap_sfr_req_t;
endpackage

// *** design/cap_counter_array.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Two blocks, each one 16-bit up-counter shared by three modules.
// - Counter runs freely and wraps, except cleared early in programmable PWM.
// - Counter clock from prescaler, Timer 0 overflow or external pin.
// - Prescaler divides oscillator by two to the power of 4-bit field.
// - Prescaler enable at bit 4 gates output; prescale register resets to 10h.
// - Capture, timer, toggle events may interrupt; PWM never does.
// - Each module owns one port pin; unassigned pins stay general I/O.
// - Capture copies count on rising, falling or either pin edge.
// - Each capture raises an interrupt request when enabled.
// - Timer mode compares written value with count; equality may interrupt.
// - Toggle mode inverts output pin on every compare match.
// - Fixed 8-bit PWM period is the low byte overflow, 256 clocks.
// - Fixed PWM output high once low byte reaches duty value.
// - At low byte overflow, high compare byte copies to low byte.
// - Counter readable and writable as separate low and high bytes.
// - One status register holds event flags for both blocks.
// - In programmable PWM, low byte equal to period clears counter and reloads period and duty.
`include "cap_cfg.svh"

module cap_counter_array
  import cap_pkg::*;
(
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic reset, // Asynchronous, active high
  input wire cap_sfr_req_t sfr_req, // Special-function register access
  output logic [7:0] sfr_rdata, // Read data, one cycle after the read
  input wire logic t0_ovf, // Timer 0 overflow pulse, same clock
  input wire logic [1:0] ext_clk_pin, // External count clock pins, one per block
  input wire logic [5:0] pin_in, // Module port pins, level seen at the pad
  output logic [5:0] pin_out, // Module port pin drive value
  output logic [5:0] pin_oe_n, // Low while a module drives its pin
  output logic [1:0] irq // Interrupt request per block
);

  // ========================================================
  // Address decode helpers
  function automatic logic [7:0] mode_addr(input int i);
    case (i)
      0: mode_addr = `CAP_M0_MODE;
      1: mode_addr = `CAP_M1_MODE;
      2: mode_addr = `CAP_M2_MODE;
      3: mode_addr = `CAP_M3_MODE;
      4: mode_addr = `CAP_M4_MODE;
      default: mode_addr = `CAP_M5_MODE;
    endcase
  endfunction

  function automatic logic [7:0] cmp_lo_addr(input int i);
    case (i)
      0: cmp_lo_addr = `CAP_M0_CMP_LO;
      1: cmp_lo_addr = `CAP_M1_CMP_LO;
      2: cmp_lo_addr = `CAP_M2_CMP_LO;
      3: cmp_lo_addr = `CAP_M3_CMP_LO;
      4: cmp_lo_addr = `CAP_M4_CMP_LO;
      default: cmp_lo_addr = `CAP_M5_CMP_LO;
    endcase
  endfunction

  function automatic logic [7:0] cmp_hi_addr(input int i);
    case (i)
      0: cmp_hi_addr = `CAP_M0_CMP_HI;
      1: cmp_hi_addr = `CAP_M1_CMP_HI;
      2: cmp_hi_addr = `CAP_M2_CMP_HI;
      3: cmp_hi_addr = `CAP_M3_CMP_HI;
      4: cmp_hi_addr = `CAP_M4_CMP_HI;
      default: cmp_hi_addr = `CAP_M5_CMP_HI;
    endcase
  endfunction

  function automatic logic [7:0] blk_addr(input int b, input logic [7:0] a0, input logic [7:0] a1);
    blk_addr = (b == 0) ? a0 : a1;
  endfunction

  // ========================================================
  // Registers
  logic [15:0] count_reg [2];
  logic [7:0] ctrl_reg [2];
  logic [7:0] prescale_reg [2];
  logic [7:0] period_reg [2];
  logic [7:0] period_act_reg [2];
  logic [14:0] div_reg [2];
  cap_mode_reg_t mode_reg [6];
  logic [7:0] cmp_lo_reg [6];
  logic [7:0] cmp_hi_reg [6];
  logic [5:0] status_reg;
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic [5:0] pin_s3_reg;
  logic [1:0] ext_s1_reg;
  logic [1:0] ext_s2_reg;
  logic [1:0] ext_s3_reg;

  logic [1:0] tick;
  logic [1:0] presc_tick;
  logic [1:0] prog_blk;
  logic [1:0] period_hit;
  logic [1:0] low_ovf;
  logic [5:0] match;
  logic [5:0] cap_edge;
  logic [5:0] event_set;

  // ========================================================
  // Pin synchronisers; stage three only feeds edge detection
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
      pin_s3_reg <= 6'h00;
      ext_s1_reg <= 2'h0;
      ext_s2_reg <= 2'h0;
      ext_s3_reg <= 2'h0;
    end
    else
    begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      ext_s1_reg <= ext_clk_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // ========================================================
  // Clock source selection and event decode
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      logic [14:0] mask;
      mask = 15'((16'h0001 << prescale_reg[b][3:0]) - 16'h0001);
      presc_tick[b] = prescale_reg[b][`CAP_PS_CE_BIT] && ((div_reg[b] & mask) == mask);
      case (ctrl_reg[b][1:0])
        `CAP_CLKSEL_PRESCALE: tick[b] = presc_tick[b];
        `CAP_CLKSEL_T0OVF: tick[b] = t0_ovf;
        `CAP_CLKSEL_PIN: tick[b] = ext_s2_reg[b] && !ext_s3_reg[b];
        default: tick[b] = 1'b0;
      endcase
      tick[b] = tick[b] && ctrl_reg[b][`CAP_CTRL_RUN_BIT];
      prog_blk[b] = 1'b0;
      for (int k = 0; k < 3; k++)
        prog_blk[b] = prog_blk[b] || (mode_reg[b*3+k].mode == CAP_PWM_PROG);
      period_hit[b] = tick[b] && prog_blk[b] && (count_reg[b][7:0] == period_act_reg[b]);
      low_ovf[b] = tick[b] && (count_reg[b][7:0] == 8'hFF);
    end
    for (int i = 0; i < 6; i++)
    begin
      match[i] = tick[i/3] && mode_reg[i].cmp_en &&
                 (count_reg[i/3] == {cmp_hi_reg[i], cmp_lo_reg[i]});
      case (mode_reg[i].edge_sel)
        2'h1: cap_edge[i] = pin_s2_reg[i] && !pin_s3_reg[i];
        2'h2: cap_edge[i] = !pin_s2_reg[i] && pin_s3_reg[i];
        2'h3: cap_edge[i] = pin_s2_reg[i] ^ pin_s3_reg[i];
        default: cap_edge[i] = 1'b0;
      endcase
      case (mode_reg[i].mode)
        CAP_CAPTURE: event_set[i] = cap_edge[i];
        CAP_TIMER: event_set[i] = match[i];
        CAP_TOGGLE: event_set[i] = match[i];
        default: event_set[i] = 1'b0;
      endcase
    end
  end

  // ========================================================
  // Prescaler dividers, free running
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      div_reg[0] <= 15'h0000;
      div_reg[1] <= 15'h0000;
    end
    else
    begin
      div_reg[0] <= div_reg[0] + 15'h0001;
      div_reg[1] <= div_reg[1] + 15'h0001;
    end
  end

  // ========================================================
  // Per-block registers and counters; software writes win over counting
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int b = 0; b < 2; b++)
      begin
        count_reg[b] <= 16'h0000;
        ctrl_reg[b] <= `CAP_ZERO8;
        prescale_reg[b] <= `CAP_PRESCALE_RST;
        period_reg[b] <= `CAP_ZERO8;
        period_act_reg[b] <= `CAP_ZERO8;
      end
    end
    else
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (period_hit[b])
        begin
          count_reg[b] <= 16'h0000;
          period_act_reg[b] <= period_reg[b];
        end
        else if (tick[b])
          count_reg[b] <= count_reg[b] + 16'h0001;
        if (sfr_req.wr)
        begin
          if (sfr_req.addr == blk_addr(b, `CAP_A0_CNT_LO, `CAP_A1_CNT_LO))
            count_reg[b][7:0] <= sfr_req.wdata;
          if (sfr_req.addr == blk_addr(b, `CAP_A0_CNT_HI, `CAP_A1_CNT_HI))
            count_reg[b][15:8] <= sfr_req.wdata;
          if (sfr_req.addr == blk_addr(b, `CAP_A0_CTRL, `CAP_A1_CTRL))
            ctrl_reg[b] <= sfr_req.wdata;
          if (sfr_req.addr == blk_addr(b, `CAP_A0_PRESCALE, `CAP_A1_PRESCALE))
            prescale_reg[b] <= {3'h0, sfr_req.wdata[4:0]};
          if (sfr_req.addr == blk_addr(b, `CAP_A0_PERIOD, `CAP_A1_PERIOD))
            period_reg[b] <= sfr_req.wdata;
        end
      end
    end
  end

  // ========================================================
  // Module mode and capture/compare registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 6; i++)
      begin
        mode_reg[i] <= '0;
        cmp_lo_reg[i] <= `CAP_ZERO8;
        cmp_hi_reg[i] <= `CAP_ZERO8;
      end
    end
    else
    begin
      for (int i = 0; i < 6; i++)
      begin
        if (mode_reg[i].mode == CAP_CAPTURE && cap_edge[i])
          {cmp_hi_reg[i], cmp_lo_reg[i]} <= count_reg[i/3];
        if (mode_reg[i].mode == CAP_PWM_FIXED && low_ovf[i/3])
          cmp_lo_reg[i] <= cmp_hi_reg[i];
        if (mode_reg[i].mode == CAP_PWM_PROG && period_hit[i/3])
          cmp_lo_reg[i] <= cmp_hi_reg[i];
        if (sfr_req.wr)
        begin
          if (sfr_req.addr == mode_addr(i))
            mode_reg[i] <= cap_mode_reg_t'({sfr_req.wdata[6:3],
                           (sfr_req.wdata[2:0] > 3'h5) ? 3'h0 : sfr_req.wdata[2:0]});
          if (sfr_req.addr == cmp_lo_addr(i))
            cmp_lo_reg[i] <= sfr_req.wdata;
          if (sfr_req.addr == cmp_hi_addr(i))
            cmp_hi_reg[i] <= sfr_req.wdata;
        end
      end
    end
  end

  // ========================================================
  // Shared event status; a hardware set beats a software clear
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      status_reg <= 6'h00;
    else if (sfr_req.wr && sfr_req.addr == `CAP_STATUS)
      status_reg <= (status_reg & sfr_req.wdata[5:0]) | event_set;
    else
      status_reg <= status_reg | event_set;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      irq <= 2'h0;
    else
      for (int b = 0; b < 2; b++)
      begin
        irq[b] <= 1'b0;
        for (int k = 0; k < 3; k++)
          if (status_reg[b*3+k] && mode_reg[b*3+k].ie)
            irq[b] <= 1'b1;
      end
  end

  // ========================================================
  // Pin drive; capture, timer and unused modules leave the pin as general I/O
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_out <= 6'h00;
      pin_oe_n <= 6'h3F;
    end
    else
      for (int i = 0; i < 6; i++)
      begin
        case (mode_reg[i].mode)
          CAP_TOGGLE:
          begin
            pin_oe_n[i] <= 1'b0;
            if (match[i])
              pin_out[i] <= !pin_out[i];
          end
          CAP_PWM_FIXED:
          begin
            pin_oe_n[i] <= 1'b0;
            if (low_ovf[i/3])
              pin_out[i] <= 1'b0;
            else if (count_reg[i/3][7:0] >= cmp_lo_reg[i])
              pin_out[i] <= 1'b1;
          end
          CAP_PWM_PROG:
          begin
            pin_oe_n[i] <= 1'b0;
            if (period_hit[i/3])
              pin_out[i] <= 1'b0;
            else if (count_reg[i/3][7:0] >= cmp_lo_reg[i])
              pin_out[i] <= 1'b1;
          end
          default:
          begin
            pin_oe_n[i] <= 1'b1;
            pin_out[i] <= 1'b0;
          end
        endcase
      end
  end

  // ========================================================
  // Registered read data; unmapped addresses read zero
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      sfr_rdata <= `CAP_ZERO8;
    else
    begin
      sfr_rdata <= `CAP_ZERO8;
      for (int b = 0; b < 2; b++)
      begin
        if (sfr_req.addr == blk_addr(b, `CAP_A0_CNT_LO, `CAP_A1_CNT_LO))
          sfr_rdata <= count_reg[b][7:0];
        if (sfr_req.addr == blk_addr(b, `CAP_A0_CNT_HI, `CAP_A1_CNT_HI))
          sfr_rdata <= count_reg[b][15:8];
        if (sfr_req.addr == blk_addr(b, `CAP_A0_CTRL, `CAP_A1_CTRL))
          sfr_rdata <= ctrl_reg[b];
        if (sfr_req.addr == blk_addr(b, `CAP_A0_PRESCALE, `CAP_A1_PRESCALE))
          sfr_rdata <= prescale_reg[b];
        if (sfr_req.addr == blk_addr(b, `CAP_A0_PERIOD, `CAP_A1_PERIOD))
          sfr_rdata <= period_reg[b];
      end
      for (int i = 0; i < 6; i++)
      begin
        if (sfr_req.addr == mode_addr(i))
          sfr_rdata <= {1'b0, 7'(mode_reg[i])};
        if (sfr_req.addr == cmp_lo_addr(i))
          sfr_rdata <= cmp_lo_reg[i];
        if (sfr_req.addr == cmp_hi_addr(i))
          sfr_rdata <= cmp_hi_reg[i];
      end
      if (sfr_req.addr == `CAP_STATUS)
        sfr_rdata <= {2'h0, status_reg};
    end
  end

  // ========================================================
  // Checks
  a_prescale_reset: assert property (@(posedge sys_clk) $fell(reset) |-> prescale_reg[0] == 8'h10)
    else $error("prescale reset value wrong");
  a_count_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (!tick[0] && !sfr_req.wr) |=> $stable(count_reg[0]))
    else $error("counter moved without a tick");
  a_count_step: assert property (@(posedge sys_clk) disable iff (reset)
    (tick[0] && !period_hit[0] && !sfr_req.wr) |=> count_reg[0] == $past(count_reg[0]) + 16'h0001)
    else $error("counter did not advance");
  a_period_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (period_hit[0] && !sfr_req.wr) |=> count_reg[0] == 16'h0000)
    else $error("period match did not clear counter");
  a_capture_load: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_reg[0].mode == CAP_CAPTURE && cap_edge[0] && !sfr_req.wr)
    |=> {cmp_hi_reg[0], cmp_lo_reg[0]} == $past(count_reg[0]))
    else $error("capture did not load count");
  a_event_flag: assert property (@(posedge sys_clk) disable iff (reset)
    event_set[2] |=> status_reg[2])
    else $error("event flag lost");
  a_irq_raise: assert property (@(posedge sys_clk) disable iff (reset)
    (status_reg[0] && mode_reg[0].ie) |=> irq[0])
    else $error("enabled flag gave no interrupt");
  a_toggle_pin: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_reg[2].mode == CAP_TOGGLE && match[2]) |=> pin_out[2] != $past(pin_out[2]))
    else $error("toggle did not invert pin");
  a_pwm_low: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_reg[4].mode == CAP_PWM_FIXED && low_ovf[1]) |=> !pin_out[4] ##0 !pin_oe_n[4])
    else $error("pwm not low at overflow");
  a_pwm_reload: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_reg[4].mode == CAP_PWM_FIXED && low_ovf[1] && !sfr_req.wr)
    |=> cmp_lo_reg[4] == $past(cmp_hi_reg[4]))
    else $error("duty byte not reloaded");
  a_pwm_no_event: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_reg[4].mode == CAP_PWM_FIXED && !status_reg[4]) |=> !status_reg[4])
    else $error("pwm raised an event");

  c_capture: cover property (@(posedge sys_clk) disable iff (reset)
    mode_reg[0].mode == CAP_CAPTURE && cap_edge[0]);
  c_toggle: cover property (@(posedge sys_clk) disable iff (reset)
    mode_reg[2].mode == CAP_TOGGLE && match[2]);
  c_pwm_fixed: cover property (@(posedge sys_clk) disable iff (reset)
    mode_reg[4].mode == CAP_PWM_FIXED && low_ovf[1]);
  c_pwm_prog: cover property (@(posedge sys_clk) disable iff (reset) period_hit[0]);

endmodule

// *** verification/cap_pin_partner.sv ***
`timescale 1ns/1ps
// ==========================================================
// Far side of the module pins and count clocks
module cap_pin_partner
(
  input wire logic sys_clk, // System clock
  input wire logic [5:0] pin_out, // Module drive values
  input wire logic [5:0] pin_oe_n, // Low while a module drives
  output logic [5:0] pin_in, // Pad levels
  output logic [1:0] ext_clk_pin // External count clocks
);
  logic [5:0] far_level = 6'h00;
  initial
  begin
    ext_clk_pin = 2'h0;
  end
  // A driven pad shows the module, a released one the far side
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & far_level);
  // Clock stands low between bursts; a fifth of the system rate
  task automatic clk_burst(input int blk, input int n);
    repeat (n)
    begin
      @(negedge sys_clk);
      ext_clk_pin[blk] = 1'b1;
      repeat (2) @(negedge sys_clk);
      ext_clk_pin[blk] = 1'b0;
      repeat (2) @(negedge sys_clk);
    end
  endtask
endmodule

// *** verification/counter_array_capture_pwm_tb_top.sv ***
`timescale 1ns/1ps
`include "cap_cfg.svh"
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("unexpected %s exp=%0h got=%0h", what, exp, got); \
    end \
  end
module counter_array_capture_pwm_tb_top
  import cap_pkg::*;
;
  logic sys_clk;
  logic reset;
  cap_sfr_req_t sfr_req;
  logic [7:0] sfr_rdata;
  logic t0_ovf;
  logic [1:0] ext_clk_pin;
  logic [5:0] pin_in;
  logic [5:0] pin_out;
  logic [5:0] pin_oe_n;
  logic [1:0] irq;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'h53D6DA78;
  int mdl [256];
  logic [7:0] rw_q [$] = {8'hA2, 8'hA3, 8'hAC, 8'hAD, 8'hAF, 8'hB1, 8'hB2, 8'hB3,
    8'hB4, 8'hBA, 8'hBB, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
  logic [7:0] lo_a [6] = '{8'hAC, 8'hAF, 8'hB2, 8'hC1, 8'hC3, 8'hC5};
  logic [7:0] hi_a [6] = '{8'hAD, 8'hB1, 8'hB3, 8'hC2, 8'hC4, 8'hC6};
  logic [7:0] md_a [6] = '{8'hA9, 8'hAA, 8'hAB, 8'hBD, 8'hBE, 8'hBF};

  cap_counter_array i_cap_counter_array (
    .sys_clk(sys_clk),
    .reset(reset),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .t0_ovf(t0_ovf),
    .ext_clk_pin(ext_clk_pin),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .irq(irq)
  );
  cap_pin_partner i_cap_pin_partner (
    .sys_clk(sys_clk),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_in(pin_in),
    .ext_clk_pin(ext_clk_pin)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Bus and stimulus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_req.addr = a;
    sfr_req.wdata = d;
    sfr_req.wr = 1'b1;
    @(negedge sys_clk);
    sfr_req.wr = 1'b0;
    mdl[a] = d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    sfr_req.addr = a;
    sfr_req.rd = 1'b1;
    @(negedge sys_clk);
    d = sfr_rdata;
    sfr_req.rd = 1'b0;
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
  endtask
  task automatic t0_pulses(input int n);
    repeat (n)
    begin
      @(negedge sys_clk);
      t0_ovf = 1'b1;
      @(negedge sys_clk);
      t0_ovf = 1'b0;
    end
  endtask
  task automatic pin_stats(input int i, input int n, output int hi, output int falls);
    logic prev;
    hi = 0;
    falls = 0;
    prev = pin_out[i];
    repeat (n)
    begin
      @(negedge sys_clk);
      hi += int'(pin_out[i] === 1'b1);
      falls += int'(prev === 1'b1 && pin_out[i] === 1'b0);
      prev = pin_out[i];
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] d;
    logic [7:0] g;
    logic [7:0] base;
    logic [15:0] v;
    logic hit;
    logic p;
    int h;
    int f;
    reset = 1'b1;
    sfr_req = '0;
    t0_ovf = 1'b0;
    foreach (mdl[a])
      mdl[a] = 0;
    mdl[8'hFB] = 8'h10;
    mdl[8'hFC] = 8'h10;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    for (int a = 0; a < 256; a++)
    begin
      rd(a[7:0], d);
      `CHK("reset value", mdl[a][7:0], d)
    end
    foreach (rw_q[i])
    begin
      wr(rw_q[i], 8'($random(seed)));
      rd(rw_q[i], d);
      `CHK("readback", mdl[rw_q[i]][7:0], d)
    end
    wr(8'hA0, 8'($random(seed)));
    rd(8'hA0, d);
    `CHK("unmapped", 8'h00, d)
    wr(`CAP_A0_PRESCALE, 8'hFF);
    rd(`CAP_A0_PRESCALE, d);
    `CHK("prescale bits", 8'h1F, d)
    for (int b = 0; b < 2; b++)
    begin
      base = b ? `CAP_A1_CNT_LO : `CAP_A0_CNT_LO;
      wr(base, 8'hFE);
      wr(base + 8'h01, 8'hFF);
      wr(base + 8'h02, 8'h41);
      t0_pulses(5);
      wr(base + 8'h02, 8'h00);
      rd16(base, v);
      `CHK("wrapped count", 16'h0003, v)
      wr(base + 8'h02, 8'h42);
      i_cap_pin_partner.clk_burst(b, 7);
      repeat (4) @(negedge sys_clk);
      wr(base + 8'h02, 8'h00);
      rd16(base, v);
      `CHK("pin clock count", 16'h000A, v)
      wr(b ? `CAP_A1_PRESCALE : `CAP_A0_PRESCALE, 8'h03);
      wr(base + 8'h02, 8'h40);
      repeat (40) @(negedge sys_clk);
      rd16(base, v);
      `CHK("gated count", 16'h000A, v)
      wr(b ? `CAP_A1_PRESCALE : `CAP_A0_PRESCALE, 8'h13);
      repeat (80) @(negedge sys_clk);
      wr(base + 8'h02, 8'h00);
      rd16(base, v);
      `CHK("divide by 8", 1'b1, v >= 16'h0013 && v <= 16'h0015)
    end
    for (int k = 0; k < 6; k += 3)
    begin
      for (int e = 1; e < 4; e++)
      begin
        for (int lv = 1; lv >= 0; lv--)
        begin
          v = 16'($random(seed));
          wr(k ? 8'hBA : 8'hA2, v[7:0]);
          wr(k ? 8'hBB : 8'hA3, v[15:8]);
          wr(md_a[k], 8'h41 | 8'(e << 3));
          i_cap_pin_partner.far_level[k] = lv[0];
          repeat (6) @(negedge sys_clk);
          hit = lv ? e[0] : e[1];
          if (hit)
          begin
            mdl[lo_a[k]] = v[7:0];
            mdl[hi_a[k]] = v[15:8];
          end
          rd(lo_a[k], d);
          `CHK("captured low", mdl[lo_a[k]][7:0], d)
          rd(hi_a[k], d);
          `CHK("captured high", mdl[hi_a[k]][7:0], d)
          rd(`CAP_STATUS, d);
          `CHK("capture flag", hit ? 8'(1 << k) : 8'h00, d)
          `CHK("capture request", hit, irq[k / 3])
          wr(`CAP_STATUS, 8'h00);
        end
      end
      wr(md_a[k], 8'h00);
    end
    wr(8'hA2, 8'h03);
    wr(8'hA3, 8'h00);
    wr(8'hAF, 8'h05);
    wr(8'hB1, 8'h00);
    wr(8'hB2, 8'h07);
    wr(8'hB3, 8'h00);
    wr(8'hAA, 8'h62);
    wr(8'hAB, 8'h23);
    wr(8'hA4, 8'h41);
    repeat (3) @(negedge sys_clk);
    p = pin_out[2];
    `CHK("toggle pin driven", 1'b0, pin_oe_n[2])
    t0_pulses(2);
    repeat (3) @(negedge sys_clk);
    rd(`CAP_STATUS, d);
    `CHK("early match", 8'h00, d)
    t0_pulses(1);
    repeat (3) @(negedge sys_clk);
    rd(`CAP_STATUS, d);
    `CHK("timer match", 8'h02, d)
    `CHK("timer request", 1'b1, irq[0])
    `CHK("pin before match", p, pin_out[2])
    t0_pulses(2);
    repeat (3) @(negedge sys_clk);
    `CHK("pin after match", ~p, pin_out[2])
    wr(8'hAA, 8'h00);
    wr(8'hAB, 8'h00);
    wr(`CAP_STATUS, 8'h00);
    wr(8'hA4, 8'h00);
    d = 8'h10 + 8'($random(seed) & 32'hBF);
    wr(8'hC4, d);
    wr(8'hC3, 8'h00);
    wr(8'hBE, 8'h44);
    wr(8'hFC, 8'h10);
    wr(8'hBC, 8'h40);
    repeat (300) @(negedge sys_clk);
    rd(8'hC3, g);
    `CHK("duty reload", d, g)
    pin_stats(4, 512, h, f);
    `CHK("pwm periods", 2, f)
    `CHK("pwm high time", 1'b1, h / 2 >= 255 - d && h / 2 <= 256 - d)
    `CHK("pwm request", 1'b0, irq[1])
    wr(8'hBC, 8'h00);
    wr(8'hBE, 8'h00);
    wr(8'hB4, 8'h20);
    // Block 0 still divides by 8 from the prescaler test; count every cycle here
    wr(`CAP_A0_PRESCALE, 8'h10);
    wr(8'hAD, 8'h08);
    wr(8'hB1, 8'h10);
    wr(8'hA2, 8'h00);
    wr(8'hA3, 8'h00);
    wr(8'hA9, 8'h05);
    wr(8'hAA, 8'h05);
    wr(8'hA4, 8'h40);
    repeat (100) @(negedge sys_clk);
    pin_stats(1, 330, h, f);
    `CHK("period matches", 10, f)
    rd(8'hA3, d);
    `CHK("early clear", 8'h00, d)
    rd(`CAP_STATUS, d);
    `CHK("pwm flags", 8'h00, d)
    wr(8'hBA, 8'h55);
    wr(8'hBB, 8'h00);
    wr(8'hBC, 8'h43);
    t0_pulses(3);
    wr(8'hBC, 8'h00);
    rd16(8'hBA, v);
    `CHK("no source count", 16'h0055, v)
    wr(8'hBD, 8'h0E);
    rd(8'hBD, d);
    `CHK("refused mode", 8'h08, d)
    `CHK("pin released", 1'b1, pin_oe_n[3])
    wr(8'hBD, 8'h00);
    tally_and_finish();
  end
endmodule
